// ===== src/low_power_and_reset_status.sv
// Function
// - wait or stop instruction pulses the clear of the interrupt mask
// - wait mode stops processor clocks, peripheral clocks keep running
// - enabled interrupt in wait wakes core; stacking and processor clocks start together one cycle later
// - any reset or emulation break request also ends wait mode
// - break ending wait mode sets the break wait exit flag
// - watchdog runs, also in wait, while its disable bit is zero
// - stop resets the system counter and gates both clock generator outputs
// - interrupt ends stop; stacking starts after full recovery time
// - any reset leaves stop mode at once
// - recovery lasts 4096 crystal cycles, or 32 with short recovery set
// - counter held in reset until recovery starts, then times recovery
// - reading the reset cause register clears all its flags
// - power-on reset sets power-on flag and clears all others
// - other resets set only their own flag, others kept
// - separate flags for pin, watchdog, opcode, low voltage, opcode-fetch address
// - monitor entry flag set on monitor entry after power-on with blank vector
// - other modules may clear flags in break only with clear enable set
// - flags cleared in break stay cleared; two-step clears stay protected
//
// The APB slave port was chosen for this implementation.
module low_power_and_reset_status (
  // apb clock and power-on reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // instruction decode
  input  wire logic        wait_exec,
  input  wire logic        stop_exec,
  output logic             imask_clear,
  output logic             stack_start,
  // wake sources
  input  wire logic        wait_irq,
  input  wire logic        stop_irq,
  input  wire logic        break_req,
  input  wire logic        emulation_mode,
  input  wire logic        in_break,
  // reset sources, one-cycle pulses
  input  wire logic        pin_reset,
  input  wire logic        watchdog_timeout,
  input  wire logic        illegal_opcode,
  input  wire logic        illegal_addr,
  input  wire logic        opcode_fetch,
  input  wire logic        monitor_entry,
  input  wire logic        low_voltage,
  // configuration
  input  wire logic        watchdog_disable_cfg,
  input  wire logic        short_stop_recovery,
  input  wire logic        xclk_tick,
  // clock gating
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             clock_gen_bus_out_en,
  output logic             crystal_clock_out_en,
  output logic             watchdog_run,
  output logic             sys_counter_clear,
  output logic             status_clear_allow,
  output logic [2:0]       power_mode
);

  lp_reset_pkg::power_mode_t mode_r;
  lp_reset_pkg::power_mode_t mode_nxt;

  logic [7:0]  reset_cause_r;
  logic [7:0]  reset_cause_nxt;
  logic [7:0]  cause_set;
  logic        break_wait_exit_flag_r;
  logic        break_clear_enable_r;
  logic        any_reset;
  logic        recover_done;
  logic        acc_phase;
  logic        commit;
  logic        idx_ok;
  logic [15:0] idx;
  logic        hit_status;
  logic        hit_cause;
  logic        hit_ctrl;
  logic        break_wake;
  logic        wait_wake;

  assign any_reset = pin_reset | watchdog_timeout | illegal_opcode
                   | (illegal_addr & opcode_fetch) | monitor_entry | low_voltage;

  // apb decode
  assign idx        = paddr[17:2];
  assign idx_ok     = paddr[31:18] == 14'h0000 && paddr[1:0] == 2'h0;
  assign hit_status = idx_ok && idx == lp_reset_pkg::IDX_BREAK_STATUS;
  assign hit_cause  = idx_ok && idx == lp_reset_pkg::IDX_RESET_CAUSE;
  assign hit_ctrl   = idx_ok && idx == lp_reset_pkg::IDX_BREAK_CTRL;
  assign acc_phase  = psel && penable;
  assign commit     = acc_phase && pready;

  // one wait state: answer registered in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= acc_phase && !pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (ce) begin
      pslverr <= acc_phase && !pready && !(hit_status || hit_cause || hit_ctrl);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      prdata <= 32'h0000_0000;
      if (acc_phase && !pready && !pwrite) begin
        if (hit_status) begin
          prdata[lp_reset_pkg::BIT_BREAK_WAIT_EXIT] <= break_wait_exit_flag_r;
        end
        if (hit_cause) begin
          prdata[7:0] <= reset_cause_r;
        end
        if (hit_ctrl) begin
          prdata[lp_reset_pkg::BIT_BREAK_CLEAR_ENABLE] <= break_clear_enable_r;
        end
      end
    end
  end

  // reset cause flags
  always_comb begin
    cause_set = 8'h00;
    cause_set[lp_reset_pkg::BIT_PIN_RESET]       = pin_reset;
    cause_set[lp_reset_pkg::BIT_WATCHDOG_RESET]  = watchdog_timeout;
    cause_set[lp_reset_pkg::BIT_ILLEGAL_OPCODE]  = illegal_opcode;
    cause_set[lp_reset_pkg::BIT_ILLEGAL_ADDRESS] = illegal_addr & opcode_fetch;
    cause_set[lp_reset_pkg::BIT_MONITOR_ENTRY]   = monitor_entry;
    cause_set[lp_reset_pkg::BIT_LOW_VOLTAGE]     = low_voltage;
  end

  // a new cause in the read cycle survives the clear
  always_comb begin
    reset_cause_nxt = reset_cause_r;
    if (commit && !pwrite && hit_cause) begin
      reset_cause_nxt = 8'h00;
    end
    reset_cause_nxt = reset_cause_nxt | cause_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_cause_r <= lp_reset_pkg::RESET_CAUSE_POR;
    end else if (ce) begin
      reset_cause_r <= reset_cause_nxt;
    end
  end

  // break wait exit flag, cleared by writing zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_wait_exit_flag_r <= lp_reset_pkg::BREAK_STATUS_RST[lp_reset_pkg::BIT_BREAK_WAIT_EXIT];
    end else if (ce) begin
      if (any_reset) begin
        break_wait_exit_flag_r <= 1'b0;
      end else if (break_wake) begin
        break_wait_exit_flag_r <= 1'b1;
      end else if (commit && pwrite && hit_status && pstrb[0]) begin
        break_wait_exit_flag_r <= break_wait_exit_flag_r
                                & pwdata[lp_reset_pkg::BIT_BREAK_WAIT_EXIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_clear_enable_r <= lp_reset_pkg::BREAK_CTRL_RST[lp_reset_pkg::BIT_BREAK_CLEAR_ENABLE];
    end else if (ce) begin
      if (any_reset) begin
        break_clear_enable_r <= 1'b0;
      end else if (commit && pwrite && hit_ctrl && pstrb[0]) begin
        break_clear_enable_r <= pwdata[lp_reset_pkg::BIT_BREAK_CLEAR_ENABLE];
      end
    end
  end

  // outside break clears are free; inside only with the enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_clear_allow <= 1'b1;
    end else if (ce) begin
      status_clear_allow <= !in_break || break_clear_enable_r;
    end
  end

  // power mode sequencing
  assign wait_wake  = mode_r == lp_reset_pkg::MODE_WAIT && wait_irq;
  assign break_wake = mode_r == lp_reset_pkg::MODE_WAIT && break_req && emulation_mode;

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      lp_reset_pkg::MODE_RUN: begin
        if (stop_exec) begin
          mode_nxt = lp_reset_pkg::MODE_STOP_HOLD;
        end else if (wait_exec) begin
          mode_nxt = lp_reset_pkg::MODE_WAIT;
        end
      end
      lp_reset_pkg::MODE_WAIT: begin
        if (wait_wake || break_wake) begin
          mode_nxt = lp_reset_pkg::MODE_RUN;
        end
      end
      lp_reset_pkg::MODE_STOP_HOLD: begin
        if (stop_irq) begin
          mode_nxt = lp_reset_pkg::MODE_STOP_RECOVER;
        end
      end
      lp_reset_pkg::MODE_STOP_RECOVER: begin
        if (recover_done) begin
          mode_nxt = lp_reset_pkg::MODE_RUN;
        end
      end
      default: begin
        mode_nxt = lp_reset_pkg::MODE_RUN;
      end
    endcase
    if (any_reset) begin
      mode_nxt = lp_reset_pkg::MODE_RUN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= lp_reset_pkg::MODE_RUN;
    end else if (ce) begin
      mode_r <= mode_nxt;
    end
  end

  stop_recovery_timer u_recovery (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .hold      (mode_r != lp_reset_pkg::MODE_STOP_RECOVER || any_reset),
    .xclk_tick (xclk_tick),
    .short_sel (short_stop_recovery),
    .done      (recover_done)
  );

  // decode strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_clear <= 1'b0;
    end else if (ce) begin
      imask_clear <= mode_r == lp_reset_pkg::MODE_RUN && (wait_exec || stop_exec) && !any_reset;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_start <= 1'b0;
    end else if (ce) begin
      stack_start <= !any_reset && (wait_wake || (mode_r == lp_reset_pkg::MODE_STOP_RECOVER
                     && recover_done));
    end
  end

  // clock gating follows the next mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en           <= 1'b1;
      periph_clk_en        <= 1'b1;
      clock_gen_bus_out_en <= 1'b1;
      crystal_clock_out_en <= 1'b1;
    end else if (ce) begin
      cpu_clk_en           <= mode_nxt == lp_reset_pkg::MODE_RUN;
      periph_clk_en        <= mode_nxt == lp_reset_pkg::MODE_RUN
                           || mode_nxt == lp_reset_pkg::MODE_WAIT;
      clock_gen_bus_out_en <= mode_nxt == lp_reset_pkg::MODE_RUN
                           || mode_nxt == lp_reset_pkg::MODE_WAIT;
      crystal_clock_out_en <= mode_nxt == lp_reset_pkg::MODE_RUN
                           || mode_nxt == lp_reset_pkg::MODE_WAIT;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_run <= 1'b0;
    end else if (ce) begin
      watchdog_run <= !watchdog_disable_cfg && (mode_nxt == lp_reset_pkg::MODE_RUN
                   || mode_nxt == lp_reset_pkg::MODE_WAIT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_counter_clear <= 1'b0;
    end else if (ce) begin
      sys_counter_clear <= mode_nxt == lp_reset_pkg::MODE_STOP_HOLD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_mode <= 3'h1;
    end else if (ce) begin
      case (mode_nxt)
        lp_reset_pkg::MODE_RUN:          power_mode <= 3'h1;
        lp_reset_pkg::MODE_WAIT:         power_mode <= 3'h2;
        lp_reset_pkg::MODE_STOP_HOLD:    power_mode <= 3'h4;
        default:                         power_mode <= 3'h0;
      endcase
    end
  end

endmodule

// ===== src/lp_reset_pkg.sv
package lp_reset_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_BREAK_STATUS  = 16'hFE00;
  localparam logic [15:0] IDX_RESET_CAUSE   = 16'hFE01;
  localparam logic [15:0] IDX_BREAK_CTRL    = 16'hFE03;

  // break_status_reg fields
  localparam int BIT_BREAK_WAIT_EXIT        = 1;
  // break_flag_ctrl_reg fields
  localparam int BIT_BREAK_CLEAR_ENABLE     = 7;

  // reset_cause_reg fields
  localparam int BIT_POWER_ON               = 7;
  localparam int BIT_PIN_RESET              = 6;
  localparam int BIT_WATCHDOG_RESET         = 5;
  localparam int BIT_ILLEGAL_OPCODE         = 4;
  localparam int BIT_ILLEGAL_ADDRESS        = 3;
  localparam int BIT_MONITOR_ENTRY          = 2;
  localparam int BIT_LOW_VOLTAGE            = 1;

  // values after power-on reset
  localparam logic [7:0]  RESET_CAUSE_POR   = 8'h80;
  localparam logic [7:0]  BREAK_STATUS_RST  = 8'h00;
  localparam logic [7:0]  BREAK_CTRL_RST    = 8'h00;

  // stop recovery lengths minus one, in crystal clock cycles
  localparam logic [11:0] RECOVER_LONG_CYC  = 12'hFFF;
  localparam logic [11:0] RECOVER_SHORT_CYC = 12'h01F;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_WAIT,
    MODE_STOP_HOLD,
    MODE_STOP_RECOVER
  } power_mode_t;

endpackage

// ===== src/stop_recovery_timer.sv
module stop_recovery_timer (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // control
  input  wire logic hold,
  input  wire logic xclk_tick,
  input  wire logic short_sel,
  // result
  output logic      done
);

  logic [11:0] count_r;
  logic [11:0] last;

  // count ends at length minus one
  assign last = short_sel ? lp_reset_pkg::RECOVER_SHORT_CYC : lp_reset_pkg::RECOVER_LONG_CYC;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= 12'h000;
    end else if (ce) begin
      if (hold || done) begin
        count_r <= 12'h000;
      end else if (xclk_tick && count_r != last) begin
        count_r <= count_r + 12'h001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
    end else if (ce) begin
      done <= !hold && !done && xclk_tick && count_r == last;
    end
  end

endmodule

// ===== testbench/lp_reset_monitor.sv
module lp_reset_monitor (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       ce,
  // bus and decode
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       wait_exec,
  input wire logic       stop_exec,
  input wire logic       imask_clear,
  input wire logic       stack_start,
  // wake and reset sources
  input wire logic       wait_irq,
  input wire logic       break_req,
  input wire logic       emulation_mode,
  input wire logic       in_break,
  input wire logic       pin_reset,
  input wire logic       watchdog_timeout,
  input wire logic       illegal_opcode,
  input wire logic       illegal_addr,
  input wire logic       opcode_fetch,
  input wire logic       monitor_entry,
  input wire logic       low_voltage,
  input wire logic       watchdog_disable_cfg,
  // gating and status
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       clock_gen_bus_out_en,
  input wire logic       crystal_clock_out_en,
  input wire logic       watchdog_run,
  input wire logic       sys_counter_clear,
  input wire logic       status_clear_allow,
  input wire logic [2:0] power_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // an illegal address only resets on an opcode fetch
  wire rst_any = pin_reset | watchdog_timeout | illegal_opcode | (illegal_addr & opcode_fetch)
               | monitor_entry | low_voltage;
  wire go = ce && !rst_any;
  wire run = power_mode == 3'b001;
  mask_clear_a: assert property (go && run && (wait_exec || stop_exec) |=> imask_clear)
    else $error("mask clear missing after wait or stop");
  wait_clk_a: assert property (go && run && wait_exec && !stop_exec
    |=> !cpu_clk_en && periph_clk_en && power_mode == 3'b010) else $error("wait gating wrong");
  stop_gate_a: assert property (go && run && stop_exec
    |=> !clock_gen_bus_out_en && !crystal_clock_out_en && sys_counter_clear)
    else $error("stop gating wrong");
  wait_wake_a: assert property (go && power_mode == 3'b010 && wait_irq
    |=> stack_start && cpu_clk_en && run) else $error("wait wake wrong");
  break_exit_a: assert property (go && power_mode == 3'b010 && !wait_irq && break_req
    && emulation_mode |=> run && !stack_start) else $error("break exit wrong");
  reset_exit_a: assert property (ce && rst_any |=> run && !stack_start && !imask_clear)
    else $error("reset exit wrong");
  recover_hold_a: assert property (power_mode == 3'b000 |-> !stack_start && !cpu_clk_en)
    else $error("early stacking in recovery");
  counter_release_a: assert property ($fell(sys_counter_clear) && !$past(rst_any)
    |-> power_mode == 3'b000) else $error("counter released outside recovery");
  wdog_wait_a: assert property (power_mode == 3'b010
    |-> watchdog_run == !$past(watchdog_disable_cfg)) else $error("watchdog run wrong");
  clear_block_a: assert property (ce && rst_any ##1 ce && in_break
    |=> !status_clear_allow) else $error("clear allowed after reset");
  bus_ready_a: assert property (ce && psel && penable && !pready |=> pready)
    else $error("bus answer missing");
endmodule

bind low_power_and_reset_status lp_reset_monitor u_lp_reset_monitor (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pready(pready),
  .wait_exec(wait_exec), .stop_exec(stop_exec), .imask_clear(imask_clear),
  .stack_start(stack_start), .wait_irq(wait_irq), .break_req(break_req),
  .emulation_mode(emulation_mode), .in_break(in_break), .pin_reset(pin_reset),
  .watchdog_timeout(watchdog_timeout), .illegal_opcode(illegal_opcode),
  .illegal_addr(illegal_addr), .opcode_fetch(opcode_fetch), .monitor_entry(monitor_entry),
  .low_voltage(low_voltage), .watchdog_disable_cfg(watchdog_disable_cfg),
  .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
  .clock_gen_bus_out_en(clock_gen_bus_out_en), .crystal_clock_out_en(crystal_clock_out_en),
  .watchdog_run(watchdog_run), .sys_counter_clear(sys_counter_clear),
  .status_clear_allow(status_clear_allow), .power_mode(power_mode));

// ===== testbench/xtal_source.sv
module xtal_source #(parameter int DIV = 2) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // crystal tick
  output logic     xclk_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // oscillator keeps running in stop, so short recovery is safe here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      xclk_tick <= 1'b0;
    end else begin
      cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
      xclk_tick <= (cnt == DIV - 1);
    end
  end
endmodule

// ===== testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] a_bs = {14'h0000, lp_reset_pkg::IDX_BREAK_STATUS, 2'b00};
  localparam logic [31:0] a_rc = {14'h0000, lp_reset_pkg::IDX_RESET_CAUSE, 2'b00};
  localparam logic [31:0] a_bc = {14'h0000, lp_reset_pkg::IDX_BREAK_CTRL, 2'b00};
  typedef struct packed {logic [6:0] src; logic f; logic [7:0] exp;} row_t;
  // reset source pulse, opcode fetch, expected cause
  row_t rows [7] = '{16'h8040, 16'h4020, 16'h2010, 16'h1108, 16'h1000, 16'h0804, 16'h0402};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, opcode_fetch = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic wait_exec = 0, stop_exec = 0, wait_irq = 0, stop_irq = 0, break_req = 0, in_break = 0;
  logic emulation_mode = 1, watchdog_disable_cfg = 0, short_stop_recovery = 0, err, ce = 1;
  logic [6:0] rsrc = 0;
  logic pready, pslverr, imask_clear, stack_start, xclk_tick, cpu_clk_en, periph_clk_en;
  logic clock_gen_bus_out_en, crystal_clock_out_en, watchdog_run, sys_counter_clear;
  logic status_clear_allow;
  logic [2:0] power_mode;
  int num_errors = 0, n_tests = 0;
  always #5 pclk = ~pclk;
  low_power_and_reset_status u_low_power_and_reset_status (.*, .pstrb(4'hF),
    .pin_reset(rsrc[6]), .watchdog_timeout(rsrc[5]), .illegal_opcode(rsrc[4]),
    .illegal_addr(rsrc[3]), .monitor_entry(rsrc[2]), .low_voltage(rsrc[1]));
  xtal_source u_xtal_source (.pclk, .presetn, .xclk_tick);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      summarize;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input logic [6:0] s, input logic f);
    @(posedge pclk) {rsrc, opcode_fetch} <= {s, f};
    @(posedge pclk) {rsrc, opcode_fetch} <= 8'h00;
  endtask
  task automatic go_wait;
    @(posedge pclk) wait_exec <= 1'b1;
    @(posedge pclk) wait_exec <= 1'b0;
  endtask
  task automatic stop_run(input logic s, input int n);
    int t;
    int k;
    @(posedge pclk) {short_stop_recovery, stop_exec} <= {s, 1'b1};
    @(posedge pclk) stop_exec <= 1'b0;
    #1 chk({cpu_clk_en, clock_gen_bus_out_en, crystal_clock_out_en, sys_counter_clear,
            imask_clear, power_mode}, 8'h1C);
    @(posedge pclk) stop_irq <= 1'b1;
    t = 0;
    k = 0;
    while (stack_start !== 1'b1 && k < 20000) begin
      @(posedge pclk);
      k++;
      // only ticks seen while recovering are timed
      if (xclk_tick === 1'b1 && power_mode === 3'b000) t++;
    end
    stop_irq <= 1'b0;
    if (k >= 20000) begin
      num_errors++;
      summarize;
    end
    chk((t >= n && t <= n + 1) ? 32'h1 : 32'h0, 32'h1);
    chk(cpu_clk_en, 1'b1);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, a_rc, 0); chk(rd, 32'h80);
    apb(0, a_rc, 0); chk(rd, 32'h00);
    apb(0, a_bs, 0); chk(rd, 32'h00);
    for (int i = 0; i < 7; i++) begin
      pulse(rows[i].src, rows[i].f);
      apb(0, a_rc, 0); chk(rd, {24'h0, rows[i].exp});
    end
    pulse(7'h40, 0); pulse(7'h02, 0); apb(0, a_rc, 0); chk(rd, 32'h42);
    pulse(7'h40, 0);
    @(posedge pclk) presetn <= 1'b0;
    @(posedge pclk) presetn <= 1'b1;
    apb(0, a_rc, 0); chk(rd, 32'h80);
    apb(1, a_rc, 32'hFF); apb(0, a_rc, 0); chk(rd, 32'h00);
    apb(0, 32'h0003F808, 0); chk({rd[30:0], err}, 32'h1);
    go_wait;
    #1 chk({cpu_clk_en, periph_clk_en, imask_clear, watchdog_run, power_mode}, 7'h3A);
    @(posedge pclk) wait_irq <= 1'b1;
    @(posedge pclk) wait_irq <= 1'b0;
    #1 chk({stack_start, cpu_clk_en, power_mode}, 5'h19);
    go_wait;
    @(posedge pclk) break_req <= 1'b1;
    @(posedge pclk) break_req <= 1'b0;
    #1 chk({stack_start, power_mode}, 4'h1);
    apb(0, a_bs, 0); chk(rd, 32'h02);
    apb(1, a_bs, 0); apb(0, a_bs, 0); chk(rd, 32'h00);
    @(posedge pclk) {watchdog_disable_cfg, emulation_mode} <= 2'b10;
    go_wait;
    #1 chk(watchdog_run, 1'b0);
    // break without emulation must not wake; low ce freezes a pending wake
    @(posedge pclk) break_req <= 1'b1;
    @(posedge pclk) {ce, wait_irq, break_req} <= 3'b010;
    repeat (2) @(posedge pclk);
    #1 chk(power_mode, 3'b010);
    @(posedge pclk) ce <= 1'b1;
    @(posedge pclk) {wait_irq, emulation_mode} <= 2'b01;
    #1 chk({stack_start, power_mode}, 4'h9);
    go_wait; pulse(7'h40, 0); #1 chk(power_mode, 3'b001);
    @(posedge pclk) stop_exec <= 1'b1;
    @(posedge pclk) stop_exec <= 1'b0;
    pulse(7'h02, 0); #1 chk(power_mode, 3'b001);
    apb(0, a_rc, 0); chk(rd, 32'h42);
    apb(1, a_bc, 32'h80); apb(0, a_bc, 0); chk(rd, 32'h80);
    @(posedge pclk) in_break <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(status_clear_allow, 1'b1);
    apb(1, a_bc, 0); repeat (2) @(posedge pclk); chk(status_clear_allow, 1'b0);
    apb(1, a_bc, 32'h80); pulse(7'h20, 0); apb(0, a_bc, 0); chk(rd, 32'h00);
    @(posedge pclk) in_break <= 1'b0;
    apb(0, a_rc, 0); chk(rd, 32'h20);
    stop_run(1'b0, 4096);
    stop_run(1'b1, 32);
    summarize;
  end
endmodule
